// >>> common/mrdc_pkg.sv
// Shared constants, types and helpers for the modem route and dial control.
// Assumes one 250 MHz clock and messages already framed by a port parser.
`default_nettype none

package mrdc_pkg;

  // ************************************************************
  // Route and register map
  // ************************************************************
  localparam int ROUTE_MAX = 8;
  localparam logic [3:0] ROUTE_MIN_LEN = 4'h2;
  localparam logic [3:0] ROUTE_MAX_LEN = 4'h8;
  localparam logic [7:0] DROP_SELF = 8'hC9;
  localparam int REG_IDX_W = 5;
  localparam int NUM_REGS = 32;
  localparam logic [4:0] REG_CMD = 5'h01;
  localparam logic [4:0] REG_STATUS = 5'h02;
  localparam logic [4:0] REG_PTR = 5'h05;
  localparam int CMD_CONNECT_BIT = 1;
  localparam int STS_CARRIER_BIT = 1;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] DIAL_END = 8'h00;
  localparam int FWD_FIFO_DEPTH = 16;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [3:0] route_len;
    logic [ROUTE_MAX-1:0][7:0] drops;
    logic is_write;
    logic [REG_IDX_W-1:0] reg_idx;
    logic [15:0] data;
  } mrdc_msg_t;

  typedef enum logic [3:0] {
    MRDC_IDLE = 4'b0001,
    MRDC_DIAL = 4'b0010,
    MRDC_WAIT = 4'b0100,
    MRDC_ONLINE = 4'b1000
  } mrdc_state_t;

  // ************************************************************
  // Helpers
  // ************************************************************
  // Route length inside the legal window
  function automatic logic route_len_ok(input mrdc_msg_t m);
    return (m.route_len >= ROUTE_MIN_LEN) && (m.route_len <= ROUTE_MAX_LEN);
  endfunction : route_len_ok

  // Final drop of the route; caller checks the length first
  function automatic logic [7:0] last_drop(input mrdc_msg_t m);
    logic [3:0] pos;
    pos = m.route_len - 4'h1;
    return m.drops[pos[2:0]];
  endfunction : last_drop

endpackage : mrdc_pkg

`default_nettype wire

// >>> design/mrdc_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and an asynchronous active-high reset.
`default_nettype none

module mrdc_fifo
  import mrdc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FWD_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  // ************************************************************
  // Storage and pointers
  // ************************************************************
  // Power-of-two depth keeps pointer wrap free of compare logic
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
    $error("mrdc_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Honest full and empty from the occupancy count
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rptr_r];

  // Write side
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  // Pointer and count update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wptr_r <= wptr_r + 1'b1;
      if (pop) rptr_r <= rptr_r + 1'b1;
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end

endmodule : mrdc_fifo

`default_nettype wire

// >>> design/mrdc_ctrl.sv
// Route filter, command register and dial/hang-up sequencer of the modem.
// Assumes host messages arrive framed on this clock; switch and carrier
// inputs are asynchronous pins.
`default_nettype none

module mrdc_ctrl
  import mrdc_pkg::*;
#(
  parameter int NREGS = NUM_REGS
) (
  input wire logic clk,
  input wire logic rst,
  input wire mrdc_msg_t msg_in,
  input wire logic msg_valid,
  output logic msg_ready,
  output mrdc_msg_t fwd_msg,
  output logic fwd_valid,
  input wire logic fwd_ready,
  input wire logic cnct_sw_in,
  input wire logic hngp_sw_in,
  input wire logic carrier_in,
  output logic [7:0] dial_char,
  output logic dial_valid,
  input wire logic dial_ready,
  output logic off_hook,
  output logic carrier_led,
  output logic [15:0] status_word,
  output logic route_err
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // Dial index wraps at the top of the file to end a runaway number
  // A mismatched file size is refused before any logic is built
  if (NREGS != (1 << REG_IDX_W)) begin : g_bad_nregs
    $error("mrdc_ctrl: NREGS must equal 2**REG_IDX_W");
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] cnct_s_r;
  logic [2:0] hngp_s_r;
  logic [1:0] carr_s_r;

  // Two flops per pin, a third stage only for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnct_s_r <= 3'h0;
      hngp_s_r <= 3'h0;
      carr_s_r <= 2'h0;
    end else begin
      cnct_s_r <= {cnct_s_r[1:0], cnct_sw_in};
      hngp_s_r <= {hngp_s_r[1:0], hngp_sw_in};
      carr_s_r <= {carr_s_r[0], carrier_in};
    end
  end

  wire cnct_edge = cnct_s_r[1] && !cnct_s_r[2];
  wire hngp_edge = hngp_s_r[1] && !hngp_s_r[2];
  wire carrier_s = carr_s_r[1];

  // ************************************************************
  // Message decode
  // ************************************************************
  mrdc_state_t state_r;
  mrdc_state_t state_nxt;
  logic [15:0] regs_r [NREGS];
  logic fifo_in_ready;

  wire online = (state_r == MRDC_ONLINE);
  wire route_ok = route_len_ok(msg_in);
  wire is_local = route_ok && (last_drop(msg_in) == DROP_SELF);
  wire fwd_push = msg_valid && route_ok && !is_local && online;
  // Forwarded traffic stalls the host only while the buffer is full
  assign msg_ready = !fwd_push || fifo_in_ready;
  wire msg_fire = msg_valid && msg_ready;

  // Status is computed, never stored, so writes to it are dropped
  wire local_wr = msg_fire && is_local && msg_in.is_write &&
                  (msg_in.reg_idx != REG_STATUS) && (msg_in.reg_idx != '0);
  wire cmd_wr = local_wr && (msg_in.reg_idx == REG_CMD);
  wire conn_old = regs_r[REG_CMD][CMD_CONNECT_BIT];
  wire conn_new = msg_in.data[CMD_CONNECT_BIT];
  wire conn_rise = cmd_wr && conn_new && !conn_old;
  wire conn_fall = cmd_wr && !conn_new && conn_old;

  // ************************************************************
  // Register file
  // ************************************************************
  // Plain storage; the command and pointer words steer the sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NREGS; i++) regs_r[i] <= REG_RESET;
    end else if (local_wr) begin
      regs_r[msg_in.reg_idx] <= msg_in.data;
    end
  end

  wire [15:0] ptr_val = regs_r[REG_PTR];
  wire ptr_ok = (ptr_val != 16'h0000) && (ptr_val < 16'(NREGS));

  // ************************************************************
  // Dial walker
  // ************************************************************
  logic [REG_IDX_W-1:0] idx_r;
  logic half_r;
  logic [7:0] dial_char_r;
  logic dial_valid_r;

  // High byte is the first character of each stored word
  wire [15:0] cur_word = regs_r[idx_r];
  wire [7:0] cur_byte = half_r ? cur_word[7:0] : cur_word[15:8];
  wire dial_busy = (state_r == MRDC_DIAL);
  wire dial_load = dial_busy && !dial_valid_r;
  wire dial_done = dial_load && ((cur_byte == DIAL_END) || (idx_r == '0));
  wire dial_take = dial_valid_r && dial_ready;

  wire hang = conn_fall || hngp_edge;
  wire start = conn_rise || cnct_edge;

  // ************************************************************
  // Call sequencer
  // ************************************************************
  // Hang-up always outranks a dial request arriving in the same cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MRDC_IDLE: begin
        if (start && !hang) begin
          state_nxt = ptr_ok ? MRDC_DIAL : MRDC_WAIT;
        end
      end
      MRDC_DIAL: begin
        if (hang) state_nxt = MRDC_IDLE;
        else if (dial_done) state_nxt = MRDC_WAIT;
      end
      MRDC_WAIT: begin
        if (hang) state_nxt = MRDC_IDLE;
        else if (carrier_s) state_nxt = MRDC_ONLINE;
      end
      MRDC_ONLINE: begin
        if (hang || !carrier_s) state_nxt = MRDC_IDLE;
      end
      default: state_nxt = MRDC_IDLE;
    endcase
  end

  // State and indicator flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= MRDC_IDLE;
      off_hook <= 1'b0;
      carrier_led <= 1'b0;
      route_err <= 1'b0;
    end else begin
      state_r <= state_nxt;
      off_hook <= (state_nxt != MRDC_IDLE);
      carrier_led <= (state_nxt == MRDC_ONLINE);
      route_err <= msg_fire && !route_ok;
    end
  end

  // Character stepping; a hang-up abandons any character in flight
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_r <= '0;
      half_r <= 1'b0;
      dial_char_r <= 8'h00;
      dial_valid_r <= 1'b0;
    end else if (state_r == MRDC_IDLE || hang) begin
      idx_r <= ptr_val[REG_IDX_W-1:0];
      half_r <= 1'b0;
      dial_valid_r <= 1'b0;
    end else if (dial_take) begin
      dial_valid_r <= 1'b0;
      half_r <= !half_r;
      if (half_r) idx_r <= idx_r + 1'b1;
    end else if (dial_load && !dial_done) begin
      dial_char_r <= cur_byte;
      dial_valid_r <= 1'b1;
    end
  end

  assign dial_char = dial_char_r;
  assign dial_valid = dial_valid_r;
  assign status_word = {14'h0000, carrier_led, 1'b0};

  // ************************************************************
  // Forward buffer
  // ************************************************************
  mrdc_fifo #(
    .WIDTH($bits(mrdc_msg_t)),
    .DEPTH(FWD_FIFO_DEPTH)
  ) u_fwd_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(msg_in),
    .in_valid(fwd_push),
    .in_ready(fifo_in_ready),
    .out_data(fwd_msg),
    .out_valid(fwd_valid),
    .out_ready(fwd_ready)
  );

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_foreign_write;
    msg_fire && msg_in.is_write && !is_local;
  endsequence

  sequence s_idle_rise_with_ptr;
    state_r == MRDC_IDLE && conn_rise && !hngp_edge && ptr_ok;
  endsequence

  sequence s_wait_then_carrier;
    state_r == MRDC_WAIT && !hang && carrier_s;
  endsequence

  property p_foreign_ignored;
    @(posedge clk) disable iff (rst)
      s_foreign_write |=> $stable(regs_r[REG_CMD]) && $stable(regs_r[REG_PTR]);
  endproperty
  a_foreign_ignored: assert property (p_foreign_ignored)
    else $error("foreign route changed a register");

  property p_dial_start;
    @(posedge clk) disable iff (rst)
      s_idle_rise_with_ptr |=> state_r == MRDC_DIAL ##1 off_hook;
  endproperty
  a_dial_start: assert property (p_dial_start)
    else $error("connect rise did not start dialing");

  property p_status_tracks_lamp;
    @(posedge clk) disable iff (rst)
      status_word[STS_CARRIER_BIT] == carrier_led &&
      carrier_led == (state_r == MRDC_ONLINE);
  endproperty
  a_status_tracks_lamp: assert property (p_status_tracks_lamp)
    else $error("status carrier bit out of step");

  // An accepted pass-through message must show at the far side next cycle
  property p_forward_push;
    @(posedge clk) disable iff (rst)
      msg_fire && route_ok && !is_local && online
      |=> fwd_valid;
  endproperty
  a_forward_push: assert property (p_forward_push)
    else $error("pass-through message not queued");

  property p_clear_hangs_up;
    @(posedge clk) disable iff (rst)
      conn_fall |=> state_r == MRDC_IDLE && !off_hook && !dial_valid;
  endproperty
  a_clear_hangs_up: assert property (p_clear_hangs_up)
    else $error("connect clear did not hang up");

  property p_switch_hangs_up;
    @(posedge clk) disable iff (rst)
      $rose(hngp_s_r[1]) |=> !off_hook && !carrier_led [*2];
  endproperty
  a_switch_hangs_up: assert property (p_switch_hangs_up)
    else $error("hang-up switch left call up");

  property p_carrier_up;
    @(posedge clk) disable iff (rst)
      s_wait_then_carrier |=> ##1 carrier_led && status_word[STS_CARRIER_BIT];
  endproperty
  a_carrier_up: assert property (p_carrier_up)
    else $error("carrier did not raise status bit");

  property p_zero_ptr_no_dial;
    @(posedge clk) disable iff (rst)
      state_r == MRDC_IDLE && start && !hang && !ptr_ok
      |=> state_r == MRDC_WAIT ##1 !dial_valid;
  endproperty
  a_zero_ptr_no_dial: assert property (p_zero_ptr_no_dial)
    else $error("dialed with pointer zero");

  property p_same_value_ignored;
    @(posedge clk) disable iff (rst)
      cmd_wr && conn_new == conn_old && state_r == MRDC_IDLE && !cnct_edge
      && !hngp_edge |=> state_r == MRDC_IDLE;
  endproperty
  a_same_value_ignored: assert property (p_same_value_ignored)
    else $error("unchanged connect bit acted on");

  property p_bad_route_flag;
    @(posedge clk) disable iff (rst)
      msg_fire && !route_ok |=> route_err;
  endproperty
  a_bad_route_flag: assert property (p_bad_route_flag)
    else $error("bad route length not flagged");

endmodule : mrdc_ctrl

`default_nettype wire

// >>> tb/mrdc_far_model.sv
// Far-end model: takes forwarded host messages and dialed characters.
// Assumes the bench drives stall just after a rising clock edge.
`default_nettype none

module mrdc_far_model
  import mrdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire mrdc_msg_t fwd_msg,
  input wire logic fwd_valid,
  output logic fwd_ready,
  input wire logic [7:0] dial_char,
  input wire logic dial_valid,
  output logic dial_ready,
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] got_q[$];
  logic [7:0] dial_q[$];

  // Stall holds both sinks off, so the block must keep its heads waiting
  assign fwd_ready = !stall;
  assign dial_ready = !stall;

  // Record each unit at the edge that completes its handshake
  always @(posedge clk) begin
    if (!rst && fwd_valid && fwd_ready) got_q.push_back(fwd_msg.data);
    if (!rst && dial_valid && dial_ready) dial_q.push_back(dial_char);
  end
endmodule : mrdc_far_model

`default_nettype wire

// >>> tb/mrdc_ctrl_test.sv
// Self-checking bench for the route filter and dial sequencer.
// Assumes the far-end model sinks forwarded messages and dial characters.
`default_nettype none

module mrdc_ctrl_test;
  import mrdc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  mrdc_msg_t msg_in = '0;
  logic msg_valid = 1'b0;
  logic msg_ready, fwd_valid, fwd_ready, dial_valid, dial_ready;
  mrdc_msg_t fwd_msg;
  logic cnct_sw_in = 1'b0;
  logic hngp_sw_in = 1'b0;
  logic carrier_in = 1'b0;
  logic stall = 1'b0;
  logic [7:0] dial_char;
  logic off_hook, carrier_led, route_err;
  logic [15:0] status_word;
  int fail_count = 0;
  int n_compared = 0;

  always #2 clk = ~clk;

  mrdc_ctrl mrdc_ctrl_inst (.clk(clk), .rst(rst), .msg_in(msg_in),
    .msg_valid(msg_valid), .msg_ready(msg_ready), .fwd_msg(fwd_msg),
    .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .cnct_sw_in(cnct_sw_in),
    .hngp_sw_in(hngp_sw_in), .carrier_in(carrier_in),
    .dial_char(dial_char), .dial_valid(dial_valid),
    .dial_ready(dial_ready), .off_hook(off_hook),
    .carrier_led(carrier_led), .status_word(status_word),
    .route_err(route_err));

  mrdc_far_model far_inst (.clk(clk), .rst(rst), .fwd_msg(fwd_msg),
    .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .dial_char(dial_char),
    .dial_valid(dial_valid), .dial_ready(dial_ready), .stall(stall));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task end_sim;
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Inputs change 1 ns after the edge, clear of the sampling point
  task step(input int n = 1);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : step

  // Bounded wait for a level; running out is a mismatch and ends the run
  task automatic wait_lvl(ref logic s, input logic v, input int n,
    input string nm);
    int i;
    for (i = 0; i < n && s !== v; i++) step();
    check(nm, {15'h0000, s}, {15'h0000, v});
    if (s !== v) end_sim();
  endtask : wait_lvl

  // Host message: write to reg idx, route of len drops ending in dl
  function automatic mrdc_msg_t mk(input logic [3:0] len,
    input logic [7:0] dl, input logic [4:0] idx, input logic [15:0] d);
    mrdc_msg_t m;
    m = '0;
    m.route_len = len;
    m.drops[0] = 8'h0A;
    if (len >= 4'h2 && len <= 4'h8) m.drops[len - 4'h1] = dl;
    m.is_write = 1'b1;
    m.reg_idx = idx;
    m.data = d;
    return m;
  endfunction : mk

  // Holds valid until accepted, then lets an edge pass before the next one
  task send(input mrdc_msg_t m);
    msg_in = m;
    msg_valid = 1'b1;
    wait_lvl(msg_ready, 1'b1, 40, "msg_ready");
    step();
    msg_valid = 1'b0;
    step();
  endtask : send

  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_reset;
    check("status after reset", status_word, 16'h0000);
    check("off_hook after reset", {15'h0000, off_hook}, 16'h0000);
  endtask : t_reset

  task t_dial;
    mrdc_msg_t m;
    send(mk(4'h2, 8'hC9, 5'h0A, 16'h3134));
    send(mk(4'h2, 8'hC9, 5'h0B, 16'h3800));
    send(mk(4'h2, 8'hC9, REG_PTR, 16'h000A));
    // Bit already clear while idle: no edge, no call
    send(mk(4'h2, 8'hC9, REG_CMD, 16'h0000));
    step(4);
    check("off_hook same value", {15'h0000, off_hook}, 16'h0000);
    // Wrong final drop must leave the line on hook
    send(mk(4'h2, 8'hC8, REG_CMD, 16'h0002));
    step(8);
    check("off_hook foreign", {15'h0000, off_hook}, 16'h0000);
    // Nine drops: taken at the next edge, flagged for one cycle
    msg_in = mk(4'h9, 8'hC9, REG_CMD, 16'h0002);
    msg_valid = 1'b1;
    step();
    check("route_err pulse", {15'h0000, route_err}, 16'h0001);
    msg_valid = 1'b0;
    step();
    check("route_err clear", {15'h0000, route_err}, 16'h0000);
    step(8);
    check("off_hook bad len", {15'h0000, off_hook}, 16'h0000);
    // Longest legal route, final drop at top of its range
    m = mk(4'h8, 8'hC9, REG_CMD, 16'h0002);
    m.drops[0] = 8'hC7;
    send(m);
    wait_lvl(off_hook, 1'b1, 8, "off_hook dial");
    for (int i = 0; i < 40 && far_inst.dial_q.size() < 3; i++) step();
    step(6);
    check("dial count", 16'(far_inst.dial_q.size()), 16'h0003);
    if (far_inst.dial_q.size() < 3) end_sim();
    check("dial 0", {8'h00, far_inst.dial_q[0]}, 16'h0031);
    check("dial 1", {8'h00, far_inst.dial_q[1]}, 16'h0034);
    check("dial 2", {8'h00, far_inst.dial_q[2]}, 16'h0038);
  endtask : t_dial

  task t_online;
    carrier_in = 1'b1;
    wait_lvl(carrier_led, 1'b1, 12, "carrier_led");
    check("status online", status_word, 16'h0002);
  endtask : t_online

  // Far end stalls while 16 messages fill the buffer, the 17th must wait
  task t_fwd;
    stall = 1'b1;
    for (int i = 0; i < 16; i++) send(mk(4'h2, 8'h88, 5'h03, 16'(i)));
    msg_in = mk(4'h2, 8'h88, 5'h03, 16'h0010);
    msg_valid = 1'b1;
    step(3);
    check("ready when full", {15'h0000, msg_ready}, 16'h0000);
    stall = 1'b0;
    send(mk(4'h2, 8'h88, 5'h03, 16'h0010));
    send(mk(4'h2, 8'hC9, 5'h0C, 16'h1234));
    for (int i = 0; i < 60 && far_inst.got_q.size() < 17; i++) step();
    step(4);
    check("fwd count", 16'(far_inst.got_q.size()), 16'h0011);
    if (far_inst.got_q.size() < 17) end_sim();
    for (int i = 0; i < 17; i++) begin
      check("fwd data", far_inst.got_q[i], 16'(i));
    end
  endtask : t_fwd

  task t_hang_write;
    send(mk(4'h2, 8'hC9, REG_CMD, 16'h0000));
    wait_lvl(off_hook, 1'b0, 8, "off_hook hang");
    check("carrier_led hang", {15'h0000, carrier_led}, 16'h0000);
    carrier_in = 1'b0;
    step(4);
  endtask : t_hang_write

  task automatic pulse(ref logic pin);
    pin = 1'b1;
    step(6);
    pin = 1'b0;
    step(6);
  endtask : pulse

  task t_switch;
    int n;
    n = far_inst.dial_q.size();
    send(mk(4'h2, 8'hC9, REG_PTR, 16'h0000));
    pulse(cnct_sw_in);
    check("off_hook switch", {15'h0000, off_hook}, 16'h0001);
    check("no dial zero ptr", 16'(far_inst.dial_q.size()), 16'(n));
    carrier_in = 1'b1;
    wait_lvl(carrier_led, 1'b1, 12, "carrier_led sw");
    // Bit already clear: a zero write carries no edge
    send(mk(4'h2, 8'hC9, REG_CMD, 16'h0000));
    step(6);
    check("zero write no hang", {15'h0000, off_hook}, 16'h0001);
    send(mk(4'h2, 8'hC9, REG_CMD, 16'h0002));
    send(mk(4'h2, 8'hC9, REG_CMD, 16'h0000));
    wait_lvl(off_hook, 1'b0, 8, "off_hook one zero");
    carrier_in = 1'b0;
    step(4);
    pulse(cnct_sw_in);
    carrier_in = 1'b1;
    wait_lvl(carrier_led, 1'b1, 12, "carrier_led again");
    hngp_sw_in = 1'b1;
    wait_lvl(off_hook, 1'b0, 10, "off_hook hngp");
    check("carrier_led hngp", {15'h0000, carrier_led}, 16'h0000);
    check("status hngp", status_word, 16'h0000);
    hngp_sw_in = 1'b0;
    carrier_in = 1'b0;
    step(6);
    // Ready for another call
    cnct_sw_in = 1'b1;
    wait_lvl(off_hook, 1'b1, 10, "off_hook redial");
    cnct_sw_in = 1'b0;
  endtask : t_switch

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    step(2);
    rst = 1'b0;
    t_reset();
    t_dial();
    t_online();
    t_fwd();
    t_hang_write();
    t_switch();
    end_sim();
  end
endmodule : mrdc_ctrl_test

`default_nettype wire
